//--- hdl/csr_top.sv
`timescale 1ns/10ps
module csr_top
    import csr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic call_push_i,
    input wire logic [WORD_W-1:0] return_step_address_i,
    input wire logic call_pop_i,
    input wire logic block_open_i,
    input wire logic block_exists_i,
    input wire logic [WORD_W-1:0] open_base_i,
    input wire logic [WORD_W-1:0] open_length_i,
    input wire logic start_i,
    input wire logic [WORD_W-1:0] accum_one_low_i,
    input wire logic [WORD_W-1:0] accum_two_low_i,
    output logic busy_o,
    output logic done_o,
    output logic clear_other_cc_o,
    output csr_mem_wr_t mem_wr_o,
    output logic [WORD_W-1:0] accum_one_low_o,
    output logic [WORD_W-1:0] accum_two_low_o,
    output csr_flags_t flags_o,
    output logic [WORD_W-1:0] data_block_base_o,
    output logic [WORD_W-1:0] data_block_length_o,
    output logic [IDX_W-1:0] stack_depth_o,
    output logic stack_full_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_FINISH} csr_state_t;

    csr_state_t state_reg;
    logic [WORD_W-1:0] base_reg;
    logic [WORD_W-1:0] len_reg;
    logic open_reg;
    logic exists_reg;
    logic [WORD_W-1:0] off_reg;
    logic [IDX_W-1:0] count_reg;
    logic [IDX_W-1:0] first_idx_reg;
    logic [IDX_W-1:0] elem_reg;
    logic [1:0] word_reg;
    logic [WORD_W-1:0] res_count_reg;
    csr_flags_t res_flags_reg;
    logic done_reg;
    csr_mem_wr_t mem_wr_reg;
    logic [WORD_W-1:0] acc1_reg;
    logic [WORD_W-1:0] acc2_reg;
    csr_flags_t flags_reg;

    csr_entry_t push_entry;
    csr_entry_t rd_entry;
    csr_entry_t top_entry;
    logic [IDX_W-1:0] depth;
    logic [IDX_W-1:0] rd_idx;
    logic param_bad;
    logic too_short;
    logic run_err;
    logic [IDX_W-1:0] copy_count;
    logic [WORD_W:0] words_needed;
    logic last_word;
    logic stack_busy;
    logic [7:0] elem_num;
    logic [7:0] elem_depth;
    logic [WORD_W-1:0] word_data;
    logic [WORD_W-1:0] word_addr;

    // the caller's data block context travels with each call
    assign push_entry = '{ret_addr: return_step_address_i, base: base_reg, length: len_reg};
    // stack is frozen while a readout runs so the copy sees a stable picture
    assign stack_busy = (state_reg != ST_IDLE);

    csr_stack u_stack (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .push_i(call_push_i && !stack_busy),
        .pop_i(call_pop_i && !stack_busy),
        .push_entry_i(push_entry),
        .rd_idx_i(rd_idx),
        .rd_entry_o(rd_entry),
        .top_entry_o(top_entry),
        .depth_o(depth),
        .full_o(stack_full_o)
    );

    // open loads the window; a return restores the caller's window
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            base_reg <= '0;
            len_reg <= '0;
            open_reg <= 1'b0;
            exists_reg <= 1'b0;
        end else if (ce_i) begin
            if (block_open_i) begin
                base_reg <= open_base_i;
                len_reg <= open_length_i;
                open_reg <= 1'b1;
                exists_reg <= block_exists_i;
            end else if (call_pop_i && !stack_busy && depth != '0) begin
                base_reg <= top_entry.base;
                len_reg <= top_entry.length;
            end
        end
    end

    // parameter and destination checks, evaluated against the requested count
    always_comb begin
        param_bad = (accum_one_low_i == '0) || (accum_one_low_i > MAX_REQ) || (accum_two_low_i > MAX_DW_NUM);
        words_needed = {1'b0, accum_two_low_i} + ({1'b0, accum_one_low_i} << WORDS_SHIFT);
        too_short = words_needed > {1'b0, len_reg};
        run_err = !open_reg || !exists_reg || param_bad || too_short;
        if ({10'h000, depth} < accum_one_low_i) begin
            copy_count = depth;
        end else begin
            copy_count = accum_one_low_i[IDX_W-1:0];
        end
    end

    // oldest of the copied group is written first, so the newest is stored last
    assign rd_idx = first_idx_reg + elem_reg;
    assign last_word = (word_reg == W_LEN) && (elem_reg == count_reg - 6'h01);
    assign elem_depth = {2'h0, rd_idx} + 8'h01;
    assign elem_num = NUM_TOP - {2'h0, rd_idx};
    assign word_addr = base_reg + off_reg + {8'h00, elem_reg, 2'h0} + {14'h0000, word_reg};

    // fixed layout inside each four word element
    always_comb begin
        unique case (word_reg)
            W_NUMBERS: word_data = {elem_num, elem_depth};
            W_RETURN: word_data = rd_entry.ret_addr;
            W_BASE: word_data = rd_entry.base;
            W_LEN: word_data = rd_entry.length;
        endcase
    end

    // sequencer: accept request, stream the words, then publish the outcome
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_reg <= ST_IDLE;
            off_reg <= '0;
            count_reg <= '0;
            first_idx_reg <= '0;
            elem_reg <= '0;
            word_reg <= W_NUMBERS;
            res_count_reg <= '0;
            res_flags_reg <= '0;
        end else if (ce_i) begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (start_i) begin
                        off_reg <= accum_two_low_i;
                        elem_reg <= '0;
                        word_reg <= W_NUMBERS;
                        first_idx_reg <= depth - copy_count;
                        if (run_err) begin
                            count_reg <= '0;
                            res_count_reg <= '0;
                            res_flags_reg <= '{logic_result_bit: 1'b1, cond_code_high: 1'b1,
                                               cond_code_low: 1'b1};
                            state_reg <= ST_FINISH;
                        end else begin
                            count_reg <= copy_count;
                            res_count_reg <= {10'h000, copy_count};
                            // deeper than requested cannot happen with fewer copied, so two compares do
                            res_flags_reg <= '{logic_result_bit: 1'b0,
                                               cond_code_high: ({10'h000, depth} > accum_one_low_i),
                                               cond_code_low: ({10'h000, depth} < accum_one_low_i)};
                            state_reg <= (copy_count == '0) ? ST_FINISH : ST_COPY;
                        end
                    end
                end
                ST_COPY: begin
                    word_reg <= word_reg + 2'h1;
                    if (word_reg == W_LEN) begin
                        elem_reg <= elem_reg + 6'h01;
                    end
                    if (last_word) begin
                        state_reg <= ST_FINISH;
                    end
                end
                ST_FINISH: begin
                    state_reg <= ST_IDLE;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // data words leave from flops, one word per enabled cycle
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            mem_wr_reg <= '0;
        end else if (ce_i) begin
            mem_wr_reg.valid <= (state_reg == ST_COPY);
            mem_wr_reg.addr <= word_addr;
            mem_wr_reg.data <= word_data;
        end
    end

    // outcome is published in one cycle with the done pulse
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            done_reg <= 1'b0;
            acc1_reg <= '0;
            acc2_reg <= '0;
            flags_reg <= '0;
        end else if (ce_i) begin
            done_reg <= (state_reg == ST_FINISH);
            if (state_reg == ST_FINISH) begin
                acc1_reg <= res_count_reg;
                acc2_reg <= off_reg;
                flags_reg <= res_flags_reg;
            end
        end
    end

    assign mem_wr_o = mem_wr_reg;
    assign done_o = done_reg;
    assign clear_other_cc_o = done_reg;
    assign busy_o = stack_busy || done_reg;
    assign accum_one_low_o = acc1_reg;
    assign accum_two_low_o = acc2_reg;
    assign flags_o = flags_reg;
    assign data_block_base_o = base_reg;
    assign data_block_length_o = len_reg;
    assign stack_depth_o = depth;

    // outcome checks sampled on the done pulse, then element word checks sampled during the copy
    a_error_outcome: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && flags_o.logic_result_bit |-> flags_o.cond_code_high && flags_o.cond_code_low
            && accum_one_low_o == '0) else $error("error outcome flags or count wrong");

    // a request is at least one, so equal or more can only follow a non-zero copy
    a_cc_success: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && !flags_o.logic_result_bit |-> !(flags_o.cond_code_high && flags_o.cond_code_low)
            && (flags_o.cond_code_low || accum_one_low_o != '0))
        else $error("success condition codes inconsistent");

    a_count_range: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o |-> accum_one_low_o <= MAX_REQ) else $error("copied count out of range");

    a_offset_kept: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && !flags_o.logic_result_bit |-> accum_two_low_o == off_reg)
        else $error("offset not returned");

    a_word_stride: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && mem_wr_o.valid && state_reg == ST_COPY |=> !ce_i
            || (mem_wr_o.valid && mem_wr_o.addr == $past(mem_wr_o.addr) + 16'h0001))
        else $error("element words not consecutive");

    a_newest_last: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_reg == ST_COPY && last_word |-> rd_idx == depth - 6'h01)
        else $error("newest element not stored last");

    a_number_depth: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_reg == ST_COPY && word_reg == W_NUMBERS |-> elem_num + elem_depth == NUM_TOP + 8'h01
            && elem_depth >= 8'h01 && elem_depth <= NUM_TOP)
        else $error("element number and depth disagree");

    a_reserve_count: assert property (@(posedge core_clk_i) disable iff (reset_i)
        state_reg == ST_COPY && last_word |-> elem_num - 8'h01 == NUM_TOP - {2'h0, depth})
        else $error("last element number does not give free slots");

    // a refused request goes straight to finish: no word in flight, done on the second edge
    a_error_nowrite: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && state_reg == ST_IDLE && start_i && run_err |=> !mem_wr_o.valid ##1 (done_o && !mem_wr_o.valid))
        else $error("erroneous request wrote memory");

    a_open_loads: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && block_open_i |=> data_block_base_o == $past(open_base_i)
            && data_block_length_o == $past(open_length_i))
        else $error("open did not load base and length");

    a_cc_clear: assert property (@(posedge core_clk_i) disable iff (reset_i)
        $rose(done_o) |-> clear_other_cc_o && $past(state_reg) == ST_FINISH)
        else $error("condition code clear missing");

    // request capture: the count never grows past the request, the offset is kept as given
    a_count_request: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && state_reg == ST_IDLE && start_i |=> res_count_reg <= $past(accum_one_low_i))
        else $error("copied count above the request");

    a_offset_capture: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && state_reg == ST_IDLE && start_i |=> off_reg == $past(accum_two_low_i))
        else $error("offset not captured at start");

    // the first word lands at the window base plus the requested data word number
    a_first_address: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && state_reg == ST_IDLE && start_i && !run_err && copy_count != '0
        |-> ##2 mem_wr_o.valid && mem_wr_o.addr == $past(data_block_base_o, 2) + $past(accum_two_low_i, 2))
        else $error("first element word misplaced");

    // the length check at start must keep every word inside the open block
    a_write_inside: assert property (@(posedge core_clk_i) disable iff (reset_i)
        mem_wr_o.valid |-> mem_wr_o.addr - data_block_base_o < data_block_length_o)
        else $error("element word outside the open block");

    // stack side: a return restores the caller's window, busy or frozen leaves the depth alone
    a_pop_restore: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && call_pop_i && !stack_busy && stack_depth_o != '0 && !block_open_i
        |=> data_block_base_o == $past(top_entry.base) && data_block_length_o == $past(top_entry.length))
        else $error("return did not restore the window");

    a_stack_frozen: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !ce_i || stack_busy |=> stack_depth_o == $past(stack_depth_o))
        else $error("stack changed while busy or frozen");

    a_full_refused: assert property (@(posedge core_clk_i) disable iff (reset_i)
        ce_i && stack_full_o && call_push_i && !call_pop_i |=> stack_full_o)
        else $error("call accepted on a full stack");
endmodule : csr_top

//--- hdl/csr_pkg.sv
// What this block does
// - keep up to 62 called, unfinished blocks on a stack in call order from the first; a further call is dropped
// - each element yields return step address, data block base and data block length
// - four consecutive words per element; caller opens a block long enough
// - copy the newest elements: request n gives the n most recent ones
// - after success accum_two_low still holds the destination offset
// - accum_one_low returns the copied count 0 to 62, never above the request
// - on success clear result bit, set the condition codes from depth against request, clear other codes
// - fewer gives high 0 low 1, equal 0 0, more 1 0, result bit 0
// - on error set result bit and both codes, clear others, accum_one_low zero
// - errors: no block open, block missing or short, illegal parameters
// - each element carries number counting 62 down to 1 and depth 1 up to 62
// - number of the last stored element minus one gives the free stack slots
// - opening a block loads base with word zero address and length without header
package csr_pkg;
    localparam int WORD_W = 16;
    localparam int IDX_W = 6;
    localparam int STACK_DEPTH = 62;
    localparam logic [WORD_W-1:0] MAX_REQ = 16'h003E;
    localparam logic [WORD_W-1:0] MAX_DW_NUM = 16'h00FF;
    localparam logic [7:0] NUM_TOP = 8'h3E;
    localparam logic [IDX_W-1:0] DEPTH_FULL = 6'h3E;
    localparam logic [1:0] W_NUMBERS = 2'h0;
    localparam logic [1:0] W_RETURN = 2'h1;
    localparam logic [1:0] W_BASE = 2'h2;
    localparam logic [1:0] W_LEN = 2'h3;
    localparam int WORDS_SHIFT = 2;

    typedef struct packed {
        logic [WORD_W-1:0] ret_addr;
        logic [WORD_W-1:0] base;
        logic [WORD_W-1:0] length;
    } csr_entry_t;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] addr;
        logic [WORD_W-1:0] data;
    } csr_mem_wr_t;

    typedef struct packed {
        logic logic_result_bit;
        logic cond_code_high;
        logic cond_code_low;
    } csr_flags_t;
endpackage : csr_pkg

//--- hdl/csr_stack.sv
`timescale 1ns/10ps
module csr_stack
    import csr_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic push_i,
    input wire logic pop_i,
    input wire csr_entry_t push_entry_i,
    input wire logic [IDX_W-1:0] rd_idx_i,
    output csr_entry_t rd_entry_o,
    output csr_entry_t top_entry_o,
    output logic [IDX_W-1:0] depth_o,
    output logic full_o
);
    csr_entry_t slot_reg [STACK_DEPTH];
    logic [IDX_W-1:0] depth_reg;

    assign full_o = (depth_reg == DEPTH_FULL);
    assign depth_o = depth_reg;
    assign rd_entry_o = slot_reg[rd_idx_i];
    assign top_entry_o = (depth_reg == '0) ? '0 : slot_reg[depth_reg - 6'h01];

    // slot 0 is the oldest call; a push on a full stack is dropped, pop on empty ignored
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            depth_reg <= '0;
        end else if (ce_i) begin
            if (push_i && !full_o) begin
                slot_reg[depth_reg] <= push_entry_i;
                depth_reg <= depth_reg + 6'h01;
            end else if (pop_i && depth_reg != '0) begin
                depth_reg <= depth_reg - 6'h01;
            end
        end
    end
endmodule : csr_stack

//--- tb/csr_top_tb.sv
`timescale 1ns/10ps
module csr_top_tb;
    import csr_pkg::*;
    logic core_clk_i, reset_i, ce_i, call_push_i, call_pop_i, block_open_i, block_exists_i, start_i;
    logic [WORD_W-1:0] return_step_address_i, open_base_i, open_length_i, accum_one_low_i, accum_two_low_i;
    logic busy_o, done_o, clear_other_cc_o, stack_full_o;
    csr_mem_wr_t mem_wr_o;
    csr_flags_t flags_o;
    logic [WORD_W-1:0] accum_one_low_o, accum_two_low_o, data_block_base_o, data_block_length_o;
    logic [IDX_W-1:0] stack_depth_o;
    int failures = 0;
    int cmp_count = 0;
    int seed = 35280;
    // reference model of the call stack and the open window
    logic [WORD_W-1:0] m_ret[$], m_base[$], m_len[$];
    logic [WORD_W-1:0] cur_base = 16'h0000, cur_len = 16'h0000;
    logic opened = 1'b0, exists_m = 1'b0;
    // expected results noted by the driver, consumed by the monitor
    logic [34:0] exp_wr[$], exp_dn[$];

    csr_top DUT (.core_clk_i(core_clk_i), .reset_i(reset_i), .ce_i(ce_i), .call_push_i(call_push_i),
        .return_step_address_i(return_step_address_i), .call_pop_i(call_pop_i), .block_open_i(block_open_i),
        .block_exists_i(block_exists_i), .open_base_i(open_base_i), .open_length_i(open_length_i),
        .start_i(start_i), .accum_one_low_i(accum_one_low_i), .accum_two_low_i(accum_two_low_i),
        .busy_o(busy_o), .done_o(done_o), .clear_other_cc_o(clear_other_cc_o), .mem_wr_o(mem_wr_o),
        .accum_one_low_o(accum_one_low_o), .accum_two_low_o(accum_two_low_o), .flags_o(flags_o),
        .data_block_base_o(data_block_base_o), .data_block_length_o(data_block_length_o),
        .stack_depth_o(stack_depth_o), .stack_full_o(stack_full_o));

    // 100 MHz clock
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end

    task automatic check(input logic [34:0] seen, input logic [34:0] exp, input string what);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict

    // monitor: every write and every completion is matched against the oldest note
    always @(posedge core_clk_i) begin
        if (!reset_i && mem_wr_o.valid === 1'b1) begin
            if (exp_wr.size() == 0) check(35'(1), 35'(0), "unexpected memory write");
            else check(35'({mem_wr_o.addr, mem_wr_o.data}), exp_wr.pop_front(), "memory write");
        end
        if (!reset_i && done_o === 1'b1) begin
            check(35'(exp_wr.size()), 35'(0), "writes missing at done");
            check(35'(clear_other_cc_o), 35'(1), "clear other codes");
            if (exp_dn.size() == 0) check(35'(1), 35'(0), "unexpected done");
            else check({accum_one_low_o, accum_two_low_o, flags_o}, exp_dn.pop_front(), "outcome");
        end
    end

    task automatic open_blk(input logic [WORD_W-1:0] b, input logic [WORD_W-1:0] l, input logic ex);
        @(negedge core_clk_i);
        block_open_i = 1'b1;
        open_base_i = b;
        open_length_i = l;
        block_exists_i = ex;
        @(negedge core_clk_i);
        block_open_i = 1'b0;
        cur_base = b;
        cur_len = l;
        opened = 1'b1;
        exists_m = ex;
        check(35'({data_block_base_o, data_block_length_o}), 35'({b, l}), "window after open");
    endtask : open_blk

    task automatic push(input logic [WORD_W-1:0] r);
        @(negedge core_clk_i);
        call_push_i = 1'b1;
        return_step_address_i = r;
        @(negedge core_clk_i);
        call_push_i = 1'b0;
        if (m_ret.size() < STACK_DEPTH) begin
            m_ret.push_back(r);
            m_base.push_back(cur_base);
            m_len.push_back(cur_len);
        end
        check(35'(stack_depth_o), 35'(m_ret.size()), "depth after call");
        check(35'(stack_full_o), 35'(m_ret.size() == STACK_DEPTH), "full flag");
    endtask : push

    task automatic pop();
        @(negedge core_clk_i);
        call_pop_i = 1'b1;
        @(negedge core_clk_i);
        call_pop_i = 1'b0;
        if (m_ret.size() > 0) begin
            void'(m_ret.pop_back());
            cur_base = m_base.pop_back();
            cur_len = m_len.pop_back();
        end
        check(35'(stack_depth_o), 35'(m_ret.size()), "depth after return");
        check(35'({data_block_base_o, data_block_length_o}), 35'({cur_base, cur_len}), "window restored");
    endtask : pop

    // one readout; poke fires a return while busy, which must be ignored
    task automatic run(input logic [WORD_W-1:0] req, input logic [WORD_W-1:0] off, input logic poke);
        int d, n, i;
        logic err;
        logic [2:0] fl;
        logic [WORD_W-1:0] a;
        d = m_ret.size();
        err = !opened || !exists_m || req == 16'h0000 || req > MAX_REQ || off > MAX_DW_NUM
            || (int'(off) + 4 * int'(req) > int'(cur_len));
        n = (d < int'(req)) ? d : int'(req);
        fl = (d < int'(req)) ? 3'h1 : ((d == int'(req)) ? 3'h0 : 3'h2);
        if (err) begin
            n = 0;
            fl = 3'h7;
        end
        for (int k = 0; k < n; k++) begin
            i = d - n + k;
            a = cur_base + off + 16'(4 * k);
            exp_wr.push_back({3'h0, a, 8'(62 - i), 8'(i + 1)});
            exp_wr.push_back({3'h0, a + 16'h0001, m_ret[i]});
            exp_wr.push_back({3'h0, a + 16'h0002, m_base[i]});
            exp_wr.push_back({3'h0, a + 16'h0003, m_len[i]});
        end
        exp_dn.push_back({16'(n), off, fl});
        @(negedge core_clk_i);
        start_i = 1'b1;
        accum_one_low_i = req;
        accum_two_low_i = off;
        @(negedge core_clk_i);
        start_i = 1'b0;
        call_pop_i = poke;
        check(35'(busy_o), 35'(1), "busy after start");
        @(negedge core_clk_i);
        call_pop_i = 1'b0;
        for (int w = 0; w < 400 && done_o !== 1'b1; w++) @(negedge core_clk_i);
        check(35'(done_o), 35'(1), "done reached");
        @(negedge core_clk_i);
        check(35'(busy_o), 35'(0), "idle after done");
        check(35'(stack_depth_o), 35'(d), "stack untouched by readout");
    endtask : run

    // watchdog: the whole sequence needs well under 10k cycles
    initial begin
        #500000;
        failures++;
        print_verdict();
    end

    initial begin
        int r;
        {ce_i, call_push_i, call_pop_i, block_open_i, block_exists_i, start_i} = 6'h20;
        {return_step_address_i, open_base_i, open_length_i, accum_one_low_i, accum_two_low_i} = 80'h0;
        reset_i = 1'b1;
        repeat (8) @(negedge core_clk_i);
        reset_i = 1'b0;
        check(35'({busy_o, done_o, stack_depth_o, flags_o}), 35'(0), "reset state");
        run(16'h0001, 16'h0000, 1'b0);
        open_blk(16'h0200, 16'h0040, 1'b0);
        run(16'h0001, 16'h0000, 1'b0);
        open_blk(16'h0100, 16'h0040, 1'b1);
        run(16'h0001, 16'h0000, 1'b0);
        push(16'h1A2B);
        open_blk(16'h0300, 16'h0030, 1'b1);
        push(16'h2C3D);
        open_blk(16'h0100, 16'h0040, 1'b1);
        push(16'h3E4F);
        run(16'h0002, 16'h0005, 1'b1);
        run(16'h0003, 16'h0000, 1'b0);
        run(16'h0005, 16'h000C, 1'b0);
        run(16'h0000, 16'h0000, 1'b0);
        run(16'h003F, 16'h0000, 1'b0);
        run(16'h0001, 16'h0100, 1'b0);
        run(16'h0004, 16'h0031, 1'b0);
        run(16'h0004, 16'h0030, 1'b0);
        repeat (4) pop();
        // clock enable low: a call in that cycle must leave the stack untouched
        @(negedge core_clk_i);
        ce_i = 1'b0;
        call_push_i = 1'b1;
        @(negedge core_clk_i);
        call_push_i = 1'b0;
        ce_i = 1'b1;
        check(35'(stack_depth_o), 35'(m_ret.size()), "call taken while frozen");
        // fill the stack to its limit with random return addresses, one extra call refused
        open_blk(16'h1000, 16'h0100, 1'b1);
        repeat (63) push(16'($random(seed)));
        run(16'h003E, 16'h0000, 1'b0);
        for (int k = 0; k < 6; k++) begin
            r = 1 + (($random(seed) & 32'h7FFFFFFF) % 62);
            run(16'(r), 16'(($random(seed) & 32'h7FFFFFFF) % (257 - 4 * r)), 1'(k));
        end
        repeat (30) pop();
        run(16'h003E, 16'h0000, 1'b0);
        // a second reset empties the stack and closes the window, so the next readout fails
        @(negedge core_clk_i);
        reset_i = 1'b1;
        @(negedge core_clk_i);
        reset_i = 1'b0;
        m_ret.delete();
        m_base.delete();
        m_len.delete();
        cur_base = 16'h0000;
        cur_len = 16'h0000;
        opened = 1'b0;
        exists_m = 1'b0;
        check(35'({stack_depth_o, data_block_base_o, busy_o}), 35'(0), "state after second reset");
        run(16'h0001, 16'h0000, 1'b0);
        repeat (3) @(negedge core_clk_i);
        check(35'(exp_dn.size()), 35'(0), "outstanding completions");
        print_verdict();
    end
endmodule : csr_top_tb
